// file: nicd_pkg.sv
// Package for the indexed command decoder: offsets, fields, opcodes, types
package nicd_pkg;
  // APB byte offsets
  localparam logic [7:0] NICD_OFF_CTRL = 8'h00;
  localparam logic [7:0] NICD_OFF_DATA = 8'h10;
  localparam logic [7:0] NICD_OFF_STAT = 8'h20;
  localparam logic [7:0] NICD_OFF_CFG = 8'h24;
  // Command word fields
  localparam int NICD_CLASS_HI = 27;
  localparam int NICD_CLASS_LO = 26;
  localparam int NICD_BUF_HI = 12;
  localparam int NICD_BUF_LO = 2;
  localparam int NICD_ADDR_HI = 23;
  localparam int NICD_RAW_TYPE_HI = 1;
  localparam int NICD_OPC_PP_LO = 8;
  // Defaults and reset values
  localparam int NICD_PAGES_PER_BLOCK = 64;
  localparam int NICD_PAGE_WORDS = 512;
  localparam int NICD_PIPE_DEPTH = 4;
  localparam logic [31:0] NICD_CMD_RST = 32'h0000_0000;
  localparam logic [1:0] NICD_AREA_RST = 2'h1;
  // Control-plane opcodes
  localparam logic [15:0] NICD_OP_ERASE = 16'h0001;
  localparam logic [15:0] NICD_OP_UNLK_S = 16'h0010;
  localparam logic [15:0] NICD_OP_UNLK_E = 16'h0011;
  localparam logic [15:0] NICD_OP_LOCK = 16'h0021;
  localparam logic [15:0] NICD_OP_LTIGHT = 16'h0031;
  localparam logic [15:0] NICD_OP_SPARE = 16'h0041;
  localparam logic [15:0] NICD_OP_DEFAULT = 16'h0042;
  localparam logic [15:0] NICD_OP_MAINSP = 16'h0043;
  localparam logic [15:0] NICD_OP_RMW_LD = 16'h0060;
  localparam logic [15:0] NICD_OP_RMW_DST = 16'h0061;
  localparam logic [15:0] NICD_OP_RMW_WR = 16'h0062;
  localparam logic [15:0] NICD_OP_CPY_SRC = 16'h1000;
  localparam logic [7:0] NICD_OP_CPY_DST = 8'h11;
  localparam logic [7:0] NICD_OP_PIPE_RD = 8'h20;
  localparam logic [7:0] NICD_OP_PIPE_WR = 8'h21;
  typedef enum logic [1:0] {
    NICD_BUFFER_ACCESS_CLASS,
    NICD_PAGE_TRANSFER_CLASS,
    NICD_CONTROL_PLANE_CLASS,
    NICD_RAW_CYCLE_CLASS
  } nicd_class_e;
  typedef enum logic [3:0] {
    NICD_FOP_NONE, NICD_FOP_ERASE, NICD_FOP_UNLOCK, NICD_FOP_LOCK, NICD_FOP_LOCK_TIGHT,
    NICD_FOP_PAGE_LOAD, NICD_FOP_PROGRAM, NICD_FOP_RMW_LOAD, NICD_FOP_RMW_WRITE,
    NICD_FOP_COPY, NICD_FOP_RAW_CMD, NICD_FOP_RAW_ADDR, NICD_FOP_RAW_WR, NICD_FOP_RAW_RD
  } nicd_fop_e;
  // Request to the flash sequencer
  typedef struct packed {
    logic valid;
    nicd_fop_e op;
    logic [23:0] addr;
    logic [23:0] addr2;
    logic [7:0] count;
    logic [31:0] data;
  } nicd_flash_req_s;
  // Pipelined request held in the queue
  typedef struct packed {
    logic write;
    logic [23:0] addr;
    logic [7:0] pages;
  } nicd_pipe_s;
endpackage : nicd_pkg

// file: nicd_pipe_queue.sv
`timescale 1ns/1ps
// Small queue that holds outstanding pipelined page requests
module nicd_pipe_queue
  import nicd_pkg::*;
#(
  parameter int DEPTH = NICD_PIPE_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic push_valid,
  output logic push_ready,
  input wire nicd_pkg::nicd_pipe_s push_data,
  // Drain side
  output logic pop_valid,
  input wire logic pop_ready,
  output nicd_pkg::nicd_pipe_s pop_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  initial begin
    if (DEPTH < 1) $error("DEPTH must be at least 1");
  end
  nicd_pipe_s mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [$clog2(DEPTH+1)-1:0] cnt_r;
  wire do_push = push_valid && push_ready;
  wire do_pop = pop_valid && pop_ready;
  assign push_ready = (cnt_r != CW'(DEPTH));
  assign pop_valid = (cnt_r != '0);
  assign pop_data = mem_r[rp_r];
  assign level = cnt_r;
  always_ff @(posedge core_clk) begin
    if (do_push) mem_r[wp_r] <= push_data;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (do_pop) rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
    end
  end
endmodule : nicd_pipe_queue

// file: nicd_decoder.sv
`timescale 1ns/1ps
// Indexed command decoder: APB slave, class decode, page tracking, opcode dispatch

module nicd_decoder
  import nicd_pkg::*;
#(
  parameter int PAGES_PER_BLOCK = NICD_PAGES_PER_BLOCK,
  parameter int PAGE_WORDS = NICD_PAGE_WORDS,
  parameter int PIPE_DEPTH = NICD_PIPE_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash sequencer request
  output nicd_pkg::nicd_flash_req_s flash_req,
  input wire logic flash_ready,
  input wire logic flash_done,
  input wire logic [31:0] flash_rdata,
  // Page buffer port, raw data, no correction path
  output logic buf_en,
  output logic buf_we,
  output logic [10:0] buf_addr,
  output logic [31:0] buf_wdata,
  input wire logic [31:0] buf_rdata,
  // Page stream to and from the flash sequencer
  output logic pg_valid,
  output logic pg_we,
  output logic [31:0] pg_wdata,
  input wire logic [31:0] pg_rdata,
  // Status
  output logic unsup_cmd,
  output logic [1:0] area_mode,
  output logic page_active
);
  localparam int M = $clog2(PAGES_PER_BLOCK);
  localparam int QW = $clog2(PIPE_DEPTH + 1);
  localparam int PW = $clog2(PAGE_WORDS + 1);
  initial begin
    if (PAGES_PER_BLOCK < 2 || M > 9) $error("pages per block out of range");
    if (PAGE_WORDS < 1 || PAGE_WORDS > 2048) $error("page size out of range");
    if (PIPE_DEPTH < 1) $error("pipe depth must be positive");
    if (PIPE_DEPTH > 15) $error("pipe depth exceeds status field");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD_REQ, ST_LOAD_WAIT, ST_XFER, ST_PROG_REQ, ST_FLASH_WAIT
  } nicd_state_e;

  nicd_state_e state_r;
  nicd_state_e state_nxt;
  logic [31:0] cmd_r;
  logic dma_en_r;
  logic unsup_r;
  logic [1:0] area_r;
  logic [PW-1:0] words_r;
  logic page_write_r;
  logic [23:0] unlk_start_r;
  logic [23:0] cpy_src_r;
  logic [23:0] rmw_dst_r;
  logic [31:0] prdata_r;
  logic pend_r;
  logic [7:0] pipe_left_r;
  nicd_flash_req_s req_r;
  nicd_flash_req_s req_nxt;

  // Bus decode
  wire acc = psel && penable;
  wire hit_ctrl = (paddr == NICD_OFF_CTRL);
  wire hit_data = (paddr == NICD_OFF_DATA);
  wire hit_stat = (paddr == NICD_OFF_STAT);
  wire hit_cfg = (paddr == NICD_OFF_CFG);
  wire hit_any = hit_ctrl || hit_data || hit_stat || hit_cfg;

  // Command fields; reserved bits are simply never looked at
  wire [1:0] cls = cmd_r[NICD_CLASS_HI:NICD_CLASS_LO];
  wire [10:0] buf_word = cmd_r[NICD_BUF_HI:NICD_BUF_LO];
  wire [23:0] flash_addr = cmd_r[NICD_ADDR_HI:0];
  wire [M-1:0] page_no = cmd_r[M-1:0];
  wire [1:0] raw_type = cmd_r[NICD_RAW_TYPE_HI:0];
  wire is_buf = (cls == NICD_BUFFER_ACCESS_CLASS);
  wire is_page = (cls == NICD_PAGE_TRANSFER_CLASS);
  wire is_ctrl = (cls == NICD_CONTROL_PLANE_CLASS);
  wire is_raw = (cls == NICD_RAW_CYCLE_CLASS);

  // Control-plane word: low 16 bits only
  wire [15:0] opc = pwdata[15:0];
  wire [7:0] opc_hi = opc[15:NICD_OPC_PP_LO];
  wire [7:0] opc_pp = opc[7:0];
  wire [9:0] pipe_end = {1'b0, page_no} + {2'b0, opc_pp};
  wire crosses_block = (opc_pp == 8'h0) || (pipe_end > 10'(PAGES_PER_BLOCK));

  // Data window access qualifiers
  wire data_acc = acc && hit_data;
  wire page_busy = (state_r != ST_IDLE);
  wire page_xfer = data_acc && is_page && (state_r == ST_XFER || state_r == ST_IDLE);
  wire last_word = (words_r == PW'(PAGE_WORDS - 1));
  wire raw_data = is_raw && (raw_type == 2'h2);
  wire raw_wait = data_acc && is_raw && !dma_en_r;

  // Pipeline queue
  nicd_pipe_s q_in;
  nicd_pipe_s q_out;
  logic q_push;
  logic q_ready;
  logic q_valid;
  logic q_pop;
  logic [QW-1:0] q_level;
  // The request being drained counts as outstanding, so the limit covers it too
  wire [QW-1:0] pipe_out = q_level + QW'(pipe_left_r != 8'h0);
  wire pipe_full = (pipe_out == QW'(PIPE_DEPTH));
  assign q_in = '{write: (opc_hi == NICD_OP_PIPE_WR), addr: flash_addr, pages: opc_pp};
  wire is_pipe = (opc_hi == NICD_OP_PIPE_RD) || (opc_hi == NICD_OP_PIPE_WR);
  wire ctrl_wr = data_acc && pwrite && is_ctrl && pready;
  assign q_push = ctrl_wr && is_pipe && !crosses_block && q_ready && !pipe_full;
  assign q_pop = (state_r == ST_IDLE) && q_valid && (pipe_left_r == 8'h0) && !pend_r;

  nicd_pipe_queue #(.DEPTH(PIPE_DEPTH)) u_queue (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .push_valid(q_push),
    .push_ready(q_ready),
    .push_data(q_in),
    .pop_valid(q_valid),
    .pop_ready(q_pop),
    .pop_data(q_out),
    .level(q_level)
  );

  // Control opcode dispatch
  // Copy-destination and pipeline opcodes share their low byte with a page count
  wire op_known = (opc == NICD_OP_ERASE) || (opc == NICD_OP_UNLK_S) ||
                  (opc == NICD_OP_UNLK_E) || (opc == NICD_OP_LOCK) ||
                  (opc == NICD_OP_LTIGHT) || (opc == NICD_OP_SPARE) ||
                  (opc == NICD_OP_DEFAULT) || (opc == NICD_OP_MAINSP) ||
                  (opc == NICD_OP_RMW_LD) || (opc == NICD_OP_RMW_DST) ||
                  (opc == NICD_OP_RMW_WR) || (opc == NICD_OP_CPY_SRC) ||
                  (opc_hi == NICD_OP_CPY_DST) || is_pipe;
  wire ctrl_bad = ctrl_wr && (!op_known ||
                  (is_pipe && (crosses_block || !q_ready || pipe_full)));
  wire page_bad = data_acc && is_page && dma_en_r;
  wire other_bad = data_acc && (is_buf || is_raw) && dma_en_r;
  wire unsup_set = ctrl_bad || page_bad || other_bad;

  // Sequencer request selection
  // A request stands until the sequencer takes it; software must pace new ones
  always_comb begin
    req_nxt = req_r;
    if (req_r.valid && flash_ready) req_nxt.valid = 1'b0;
    if (state_r == ST_LOAD_REQ && !req_r.valid) begin
      req_nxt = '{valid: 1'b1, op: NICD_FOP_PAGE_LOAD, addr: flash_addr, addr2: '0,
                  count: 8'h1, data: '0};
    end else if (state_r == ST_PROG_REQ && !req_r.valid) begin
      req_nxt = '{valid: 1'b1, op: NICD_FOP_PROGRAM, addr: flash_addr, addr2: '0,
                  count: 8'h1, data: '0};
    end else if (ctrl_wr && !ctrl_bad && !dma_en_r) begin
      req_nxt.addr = flash_addr;
      req_nxt.addr2 = '0;
      req_nxt.count = 8'h1;
      req_nxt.data = '0;
      req_nxt.valid = 1'b1;
      if (opc == NICD_OP_ERASE) req_nxt.op = NICD_FOP_ERASE;
      else if (opc == NICD_OP_UNLK_E) begin
        req_nxt.op = NICD_FOP_UNLOCK;
        req_nxt.addr = unlk_start_r;
        req_nxt.addr2 = flash_addr;
      end else if (opc == NICD_OP_LOCK) req_nxt.op = NICD_FOP_LOCK;
      else if (opc == NICD_OP_LTIGHT) req_nxt.op = NICD_FOP_LOCK_TIGHT;
      else if (opc == NICD_OP_RMW_LD) req_nxt.op = NICD_FOP_RMW_LOAD;
      else if (opc == NICD_OP_RMW_WR) begin
        req_nxt.op = NICD_FOP_RMW_WRITE;
        req_nxt.addr = rmw_dst_r;
      end else if (opc_hi == NICD_OP_CPY_DST) begin
        req_nxt.op = NICD_FOP_COPY;
        req_nxt.addr = cpy_src_r;
        req_nxt.addr2 = flash_addr;
        req_nxt.count = opc_pp;
      end else req_nxt.valid = 1'b0;
    end else if (raw_wait && pready && !raw_data && pwrite) begin
      req_nxt = '{valid: 1'b1, op: (raw_type == 2'h1) ? NICD_FOP_RAW_ADDR : NICD_FOP_RAW_CMD,
                  addr: '0, addr2: '0, count: 8'h1, data: pwdata};
    end else if (raw_wait && raw_data && !pend_r && !req_r.valid) begin
      req_nxt = '{valid: 1'b1, op: pwrite ? NICD_FOP_RAW_WR : NICD_FOP_RAW_RD,
                  addr: '0, addr2: '0, count: 8'h1, data: pwdata};
    end
  end

  // Page transfer state machine
  // A page read stalls the bus until the load is done; writes stream at once
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (page_xfer && !dma_en_r) state_nxt = pwrite ? ST_XFER : ST_LOAD_REQ;
      end
      ST_LOAD_REQ: if (req_r.valid && flash_ready) state_nxt = ST_LOAD_WAIT;
      ST_LOAD_WAIT: if (flash_done) state_nxt = ST_XFER;
      ST_XFER: begin
        if (page_xfer && pready && last_word) begin
          state_nxt = page_write_r ? ST_PROG_REQ : ST_IDLE;
        end
      end
      ST_PROG_REQ: if (req_r.valid && flash_ready) state_nxt = ST_FLASH_WAIT;
      ST_FLASH_WAIT: if (flash_done) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Answer timing: page words wait for the load, raw data waits for the sequencer
  assign pready = !psel ? 1'b0 :
                  !(data_acc && !dma_en_r) ? 1'b1 :
                  is_page ? (state_r == ST_XFER) :
                  raw_data ? (pend_r && flash_done) : 1'b1;
  assign pslverr = acc && !hit_any;

  wire [31:0] stat_word = {16'h0, 4'(pipe_out), 8'h0, page_busy, area_r, unsup_r};
  wire [31:0] rd_mux = hit_ctrl ? cmd_r :
                       hit_stat ? stat_word :
                       hit_cfg ? {31'h0, dma_en_r} :
                       !hit_data ? 32'h0 :
                       is_buf ? buf_rdata :
                       is_page ? pg_rdata :
                       is_raw ? flash_rdata : 32'h0;
  // Page and raw read words arrive in the ready cycle, so they pass straight through
  assign prdata = (acc && !pwrite) ? rd_mux : prdata_r;

  // Buffer class goes straight to the buffer with no correction path
  assign buf_en = data_acc && is_buf && !dma_en_r;
  assign buf_we = pwrite;
  assign buf_addr = buf_word;
  assign buf_wdata = pwdata;
  // Full word regardless of pstrb
  assign pg_valid = page_xfer && !dma_en_r && (state_r == ST_XFER);
  assign pg_we = page_write_r;
  assign pg_wdata = pwdata;
  assign flash_req = req_r;
  assign unsup_cmd = unsup_r;
  assign area_mode = area_r;
  assign page_active = page_busy || (pipe_left_r != 8'h0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      prdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      // Last read word stays on the bus between transfers
      if (acc && pready && !pwrite) prdata_r <= rd_mux;
    end
  end

  // Command word, configuration and status registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_r <= NICD_CMD_RST;
      dma_en_r <= 1'b0;
      unsup_r <= 1'b0;
    end else begin
      if (acc && pwrite && hit_ctrl) cmd_r <= pwdata;
      if (acc && pwrite && hit_cfg && pstrb[0]) dma_en_r <= pwdata[0];
      // Set wins over a same-cycle write-one-to-clear
      if (unsup_set) unsup_r <= 1'b1;
      else if (acc && pwrite && hit_stat && pwdata[0]) unsup_r <= 1'b0;
    end
  end

  // Word count and latched control values
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      words_r <= '0;
      page_write_r <= 1'b0;
      area_r <= NICD_AREA_RST;
      unlk_start_r <= '0;
      cpy_src_r <= '0;
      rmw_dst_r <= '0;
      pend_r <= 1'b0;
      pipe_left_r <= 8'h0;
    end else begin
      if (state_r == ST_IDLE && page_xfer) begin
        words_r <= '0;
        page_write_r <= pwrite;
      end else if (pg_valid && pready) begin
        words_r <= last_word ? '0 : words_r + 1'b1;
      end
      if (ctrl_wr && !ctrl_bad) begin
        if (opc == NICD_OP_UNLK_S) unlk_start_r <= flash_addr;
        if (opc == NICD_OP_CPY_SRC) cpy_src_r <= flash_addr;
        if (opc == NICD_OP_RMW_DST) rmw_dst_r <= flash_addr;
        if (opc == NICD_OP_SPARE) area_r <= 2'h0;
        if (opc == NICD_OP_DEFAULT) area_r <= 2'h1;
        if (opc == NICD_OP_MAINSP) area_r <= 2'h2;
      end
      if (req_r.valid && flash_ready && (req_r.op == NICD_FOP_RAW_RD ||
          req_r.op == NICD_FOP_RAW_WR)) pend_r <= 1'b1;
      else if (pend_r && flash_done) pend_r <= 1'b0;
      // Pipelined pages are consumed by whole-page transfers
      if (q_pop) pipe_left_r <= q_out.pages;
      else if (pipe_left_r != 8'h0 && page_xfer && pready && last_word) begin
        pipe_left_r <= pipe_left_r - 8'h1;
      end
    end
  end
endmodule : nicd_decoder

// file: nicd_decoder_props.sv
// Port checker for the indexed command decoder
`timescale 1ns/1ps
module nicd_decoder_props
  import nicd_pkg::*;
#(
  parameter int PAGE_WORDS = NICD_PAGE_WORDS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash side
  input wire nicd_pkg::nicd_flash_req_s flash_req,
  input wire logic flash_ready,
  input wire logic buf_en,
  input wire logic [10:0] buf_addr,
  input wire logic pg_valid,
  input wire logic pg_we,
  input wire logic [31:0] pg_wdata,
  // Status
  input wire logic unsup_cmd,
  input wire logic [1:0] area_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic unmapped;
  logic [31:0] cmd_r;
  logic dma_r;
  logic [7:0] wcnt_r;
  assign acc = psel && penable && pready;
  assign unmapped = !(paddr inside {NICD_OFF_CTRL, NICD_OFF_DATA, NICD_OFF_STAT, NICD_OFF_CFG});
  // Shadow of the command word so field checks need no internal probes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_r <= '0;
      dma_r <= 1'b0;
      wcnt_r <= '0;
    end else begin
      if (acc && pwrite && paddr == NICD_OFF_CTRL) cmd_r <= pwdata;
      if (acc && pwrite && paddr == NICD_OFF_CFG) dma_r <= pwdata[0];
      if (acc && pwrite && paddr == NICD_OFF_CTRL) wcnt_r <= '0;
      else if (acc && pg_valid && pg_we) wcnt_r <= wcnt_r + 8'h01;
    end
  end
  sequence s_last_word;
    acc && pg_valid && pg_we && wcnt_r == 8'(PAGE_WORDS - 1);
  endsequence
  sequence s_prog_req;
    flash_req.valid && flash_req.op == NICD_FOP_PROGRAM;
  endsequence
  chk_prog_after_page: assert property (s_last_word |-> ##[1:20] s_prog_req)
    else $error("no program request after last page word");
  chk_unmapped_err: assert property (psel && penable && unmapped |-> pslverr)
    else $error("unmapped access without error");
  chk_ctrl_ready: assert property (psel && penable && paddr == NICD_OFF_CTRL |-> pready)
    else $error("command word access stalled");
  chk_req_hold: assert property (flash_req.valid && !flash_ready |=> $stable(flash_req))
    else $error("flash request changed before acceptance");
  chk_area_legal: assert property (area_mode != 2'h3)
    else $error("illegal area mode");
  chk_full_width: assert property (pg_valid && pg_we |-> pg_wdata == pwdata)
    else $error("page write data not full width");
  chk_buf_addr: assert property (buf_en |-> buf_addr == cmd_r[12:2] && cmd_r[27:26] == 2'h0)
    else $error("buffer address not taken from command");
  chk_dma_refuse: assert property (acc && paddr == NICD_OFF_DATA && dma_r && cmd_r[27:26] == 2'h1
      |-> !pg_valid ##1 unsup_cmd)
    else $error("page access with dma on not refused");
  chk_unsup_sticky: assert property (unsup_cmd && !(acc && pwrite && paddr == NICD_OFF_STAT
      && pwdata[0]) |=> unsup_cmd)
    else $error("unsupported flag dropped without clear");
endmodule : nicd_decoder_props

bind nicd_decoder nicd_decoder_props #(.PAGE_WORDS(PAGE_WORDS)) nicd_decoder_props_inst (.*);

// file: nicd_flash_model.sv
// Flash sequencer model facing the decoder
`timescale 1ns/1ps
module nicd_flash_model
  import nicd_pkg::*;
#(
  parameter logic [31:0] PAT = 32'hc35a_0f96
) (
  // Clock, reset and pace
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow,
  // Sequencer
  input wire nicd_pkg::nicd_flash_req_s flash_req,
  output logic flash_ready,
  output logic flash_done,
  output logic [31:0] flash_rdata,
  // Data ports
  input wire logic pg_valid,
  input wire logic pg_we,
  output logic [31:0] pg_rdata,
  input wire logic [10:0] buf_addr,
  output logic [31:0] buf_rdata
);
  logic [3:0] busy_r;
  logic [31:0] rd_r;
  assign flash_ready = busy_r == 4'h0;
  // Outside a strobe the page and flash read lines show the inverse, so stale data never matches
  assign pg_rdata = (pg_valid && !pg_we) ? PAT : ~PAT;
  assign flash_rdata = flash_done ? rd_r : ~rd_r;
  assign buf_rdata = {21'h0f0f0, buf_addr};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_r <= 4'h0;
      flash_done <= 1'b0;
      rd_r <= 32'h0;
    end else begin
      flash_done <= busy_r == 4'h1;
      if (flash_req.valid && flash_ready) begin
        busy_r <= slow ? 4'h9 : 4'h2;
        rd_r <= flash_req.data ^ 32'h00ff_ff00;
      end else if (busy_r != 4'h0) begin
        busy_r <= busy_r - 4'h1;
      end
    end
  end
endmodule : nicd_flash_model

// file: tb_nicd_decoder.sv
// Self-checking bench for the indexed command decoder
`timescale 1ns/1ps
module tb_nicd_decoder;
  import nicd_pkg::*;
  localparam int PW = 8;
  localparam int PPB = 32;
  localparam int M = 5;
  localparam logic [31:0] PAT = 32'h96f0_5ac3;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic slow = 1'b0;
  logic [31:0] prdata, flash_rdata, buf_wdata, buf_rdata, pg_wdata, pg_rdata, rd;
  logic pready, pslverr, flash_ready, flash_done, buf_en, buf_we, pg_valid, pg_we;
  logic unsup_cmd, page_active, err;
  logic [10:0] buf_addr;
  logic [1:0] area_mode;
  nicd_flash_req_s flash_req, last_req;
  int errors = 0;
  int n_tests = 0;
  int n_req = 0;
  int n0, pg, pp;
  logic [15:0] ops [7];
  nicd_fop_e fops [7];
  always #2.5 core_clk = ~core_clk;
  nicd_decoder #(.PAGE_WORDS(PW), .PAGES_PER_BLOCK(PPB)) nicd_decoder_inst (.*);
  nicd_flash_model #(.PAT(PAT)) nicd_flash_model_inst (.*);
  always @(posedge core_clk) begin
    if (flash_req.valid && flash_ready) begin
      last_req <= flash_req;
      n_req <= n_req + 1;
    end
  end
  function automatic logic [31:0] cmdw(input logic [1:0] c, input int blk, input int p);
    return {4'h0, c, 2'h0, 24'((blk << M) | p)};
  endfunction : cmdw
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; an idle cycle separates transfers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= (a == NICD_OFF_CFG) ? 4'hf : 4'($urandom);
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 400);
    if (k >= 400) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic cp(input logic [31:0] c, input logic [15:0] op);
    apb(1'b1, NICD_OFF_CTRL, c);
    apb(1'b1, NICD_OFF_DATA, {16'($urandom), op});
  endtask : cp
  task automatic unsup(input logic e);
    apb(1'b0, NICD_OFF_STAT, 32'h0);
    check(32'(rd[0]), 32'(e));
    apb(1'b1, NICD_OFF_STAT, 32'h1);
  endtask : unsup
  task automatic wait_req;
    int k;
    k = 0;
    while (n_req == n0 && k < 50) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 50) errors++;
  endtask : wait_req
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(17));
    ops = '{NICD_OP_ERASE, NICD_OP_UNLK_E, NICD_OP_LOCK, NICD_OP_LTIGHT, NICD_OP_RMW_LD,
      NICD_OP_RMW_WR, 16'h1102};
    fops = '{NICD_FOP_ERASE, NICD_FOP_UNLOCK, NICD_FOP_LOCK, NICD_FOP_LOCK_TIGHT,
      NICD_FOP_RMW_LOAD, NICD_FOP_RMW_WRITE, NICD_FOP_COPY};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, NICD_OFF_STAT, 32'h0);
    check(32'(rd[3:0]), 32'h2);
    apb(1'b0, 8'h30, 32'h0);
    check(32'(err), 32'h1);
    $display("test reset and map done");
    for (int i = 0; i < 3; i++) begin
      cp(cmdw(2'h2, 0, 0), NICD_OP_SPARE + 16'(i));
      check(32'(area_mode), 32'(i));
    end
    cp(cmdw(2'h2, 1, 0), NICD_OP_UNLK_S);
    cp(cmdw(2'h2, 1, 2), NICD_OP_CPY_SRC);
    cp(cmdw(2'h2, 2, 3), NICD_OP_RMW_DST);
    for (int i = 0; i < 7; i++) begin
      n0 = n_req;
      cp(cmdw(2'h2, i + 3, 1), ops[i]);
      wait_req();
      check(32'(last_req.op), 32'(fops[i]));
    end
    check(32'(last_req.count), 32'h2);
    unsup(1'b0);
    n0 = n_req;
    cp(cmdw(2'h2, 0, 0), 16'h0077);
    repeat (10) @(posedge core_clk);
    check(32'(n_req), 32'(n0));
    unsup(1'b1);
    unsup(1'b0);
    $display("test control plane done");
    apb(1'b1, NICD_OFF_CTRL, cmdw(2'h1, 3, 4));
    n0 = n_req;
    repeat (PW) apb(1'b1, NICD_OFF_DATA, $urandom);
    wait_req();
    check(32'(last_req.op), 32'(NICD_FOP_PROGRAM));
    check(32'(last_req.addr), 32'(cmdw(2'h1, 3, 4) & 32'h00ff_ffff));
    repeat (20) @(posedge core_clk);
    slow <= 1'b1;
    apb(1'b1, NICD_OFF_CTRL, cmdw(2'h1, 3, 4));
    for (int i = 0; i < PW; i++) begin
      apb(1'b0, NICD_OFF_DATA, 32'h0);
      check(rd, PAT);
    end
    check(32'(last_req.op), 32'(NICD_FOP_PAGE_LOAD));
    slow <= 1'b0;
    $display("test page transfer done");
    pg = $urandom_range(0, 2047);
    apb(1'b1, NICD_OFF_CTRL, {4'h0, 2'h0, 13'h0155, 11'(pg), 2'h0});
    apb(1'b0, NICD_OFF_DATA, 32'h0);
    check(rd, {21'h0f0f0, 11'(pg)});
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, NICD_OFF_CTRL, {4'h0, 2'h3, 24'h0, 2'(t)});
      n0 = n_req;
      apb(1'b1, NICD_OFF_DATA, 32'h70 + t);
      wait_req();
      check(32'(last_req.op), 32'(t == 0 ? NICD_FOP_RAW_CMD : t == 1 ? NICD_FOP_RAW_ADDR :
        NICD_FOP_RAW_WR));
      check(last_req.data, 32'h70 + t);
    end
    apb(1'b0, NICD_OFF_DATA, 32'h0);
    check(32'(last_req.op), 32'(NICD_FOP_RAW_RD));
    check(rd, 32'h00ff_ff00);
    $display("test buffer and raw done");
    apb(1'b1, NICD_OFF_CFG, 32'h1);
    n0 = n_req;
    apb(1'b1, NICD_OFF_CTRL, cmdw(2'h1, 1, 1));
    apb(1'b1, NICD_OFF_DATA, $urandom);
    repeat (5) @(posedge core_clk);
    check(32'(n_req), 32'(n0));
    unsup(1'b1);
    apb(1'b1, NICD_OFF_CFG, 32'h0);
    $display("test dma refusal done");
    cp(cmdw(2'h2, 2, 30), {NICD_OP_PIPE_WR, 8'h03});
    unsup(1'b1);
    for (int i = 0; i < 4; i++) begin
      pg = (i == 0) ? 29 : $urandom_range(0, PPB - 1);
      pp = (i == 0) ? 3 : $urandom_range(1, PPB - pg);
      cp(cmdw(2'h2, 5, pg), {i[0] ? NICD_OP_PIPE_WR : NICD_OP_PIPE_RD, 8'(pp)});
      unsup(1'b0);
    end
    apb(1'b0, NICD_OFF_STAT, 32'h0);
    check(32'(rd[14:12]), 32'h4);
    check(32'(page_active), 32'h1);
    cp(cmdw(2'h2, 6, 0), {NICD_OP_PIPE_RD, 8'h01});
    unsup(1'b1);
    $display("test pipeline done");
    end_of_test();
  end
endmodule : tb_nicd_decoder
